// ===== src/tdl_consts.svh
// Offsets, field positions, opcodes and the reset word for the 3D line setup bank.
// Assumes APB byte addressing with 32-bit aligned registers.
`ifndef TDL_CONSTS_SVH
`define TDL_CONSTS_SVH

`define TDL_ADDR_W          16
`define TDL_OFF_CMD         16'hb100
`define TDL_OFF_GB_DELTA    16'hb144
`define TDL_OFF_AR_DELTA    16'hb148
`define TDL_OFF_GB_START    16'hb14c
`define TDL_OFF_AR_START    16'hb150
`define TDL_OFF_Z_DELTA     16'hb158
`define TDL_OFF_Z_START     16'hb15c
`define TDL_OFF_ENDPOINTS   16'hb16c
`define TDL_OFF_X_DELTA     16'hb170
`define TDL_OFF_X_START     16'hb174
`define TDL_OFF_Y_START     16'hb178
`define TDL_OFF_Y_COUNT     16'hb17c
`define TDL_OFF_STATUS      16'hb180

`define TDL_BIT_AUTO        0
`define TDL_TB_LSB          15
`define TDL_FOG_BIT         17
`define TDL_ABC_LSB         18
`define TDL_ZCMP_LSB        20
`define TDL_ZUP_BIT         23
`define TDL_ZMODE_LSB       24
`define TDL_WRAP_BIT        26
`define TDL_OP_LSB          27
`define TDL_CLASS_BIT       31
`define TDL_DIR_BIT         31
`define TDL_YCNT_W          11
`define TDL_OP_NOP          4'hf
`define TDL_OP_LINE         4'h8
`define TDL_RESET_WORD      32'h0000_0000

`endif

// ===== src/tdl_line_setup.sv
// 3D line setup register bank with command decode and line stepping.
// Assumes an APB master on pclk; the pixel pipeline consumes the outputs.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tdl_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Texture blend: reflection, modulate, decal, reserved
// - Fog bit enables fog colour blending
// - Alpha blend: off, off, texture, source
// - Three-bit depth test selects compare relation
// - Depth write only when enabled and passing
// - Depth buffer scheme: normal, two mux passes
// - Texture wrap bit enables wrapping
// - Four-bit primitive opcode decode
// - No-operation write leaves auto-execute, draws nothing
// - Top bit is stored only; the class flag output and read-back bit 31 show line busy
// - Blue/green deltas, signed 8.7 halves
// - Red/alpha deltas, signed 8.7 halves
// - Depth delta is signed 16.15
// - X delta is signed 11.20
// - Lines drawn bottom to top from Y start
// - Auto-execute starts line on count write
// - Count register: 11-bit count, direction bit
module tdl_line_setup (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   output var  logic        line_busy,
   output var  logic        span_left_to_right,
   output var  logic [10:0] span_y,
   output var  logic [31:0] span_x,
   output var  logic [31:0] span_depth,
   output var  logic [63:0] span_colour,
   output var  logic        span_valid,
   output var  logic        span_depth_write_on,
   output var  logic [1:0]  texture_blend_select,
   output var  logic        fog_blend_on,
   output var  logic        alpha_blend_on,
   output var  logic        alpha_blend_source,
   output var  logic [2:0]  depth_test_select,
   output var  logic [1:0]  depth_buffer_scheme,
   output var  logic        texture_wrap_on,
   output var  logic        command_class_flag
);

   //////////////////////////////////////////////////////////////////////////
   // Register storage
   // Start values other than Y start (bits 10:0 only) are kept exactly as written; software keeps the sign
   // bits clear and the engine does not police them.
   logic [31:0]          cmd_reg;
   logic [31:0]          gb_delta_reg;
   logic [31:0]          ar_delta_reg;
   logic [31:0]          gb_start_reg;
   logic [31:0]          ar_start_reg;
   logic [31:0]          z_delta_reg;
   logic [31:0]          z_start_reg;
   logic [31:0]          endpoints_reg;
   logic [31:0]          x_delta_reg;
   logic [31:0]          x_start_reg;
   logic [10:0]          y_start_reg;
   logic [31:0]          y_count_reg;
   logic                 auto_execute_flag_reg;
   logic [10:0]          remain_reg;
   logic [63:0]          colour_acc_reg;
   tdl_pkg::tdl_state_e  state_reg;
   logic                 wr_en;
   logic                 rd_en;
   logic                 hit;
   logic                 start_line;
   logic [31:0]          rd_next;
   logic [3:0]           opcode;
   logic [10:0]          line_count;

   // Access phase qualifies every write; the slave always answers at once
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign opcode = pwdata[`TDL_OP_LSB +: 4];

   // Count written in the same access comes straight from the bus
   assign line_count = (paddr == `TDL_OFF_Y_COUNT) ?
      pwdata[10:0] : y_count_reg[10:0];

   // count write trigger
   // A direct write of a line command also starts, when auto is off.
   assign start_line = (state_reg == tdl_pkg::TDL_IDLE) && wr_en &&
      ((paddr == `TDL_OFF_Y_COUNT && auto_execute_flag_reg &&
        cmd_reg[`TDL_OP_LSB +: 4] == `TDL_OP_LINE) ||
       (paddr == `TDL_OFF_CMD && !pwdata[`TDL_BIT_AUTO] &&
        opcode == `TDL_OP_LINE));

   //////////////////////////////////////////////////////////////////////////
   // Parameter register writes
   // Writes land whether or not a line is running; the engine copies the
   // start values only at launch, so the host may preload the next line's start values; deltas apply at once.
   // Reserved bits are stored too and read back as written, except Y start keeps only bits 10:0 and Y count reads bits 30:11 as zero.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gb_delta_reg  <= `TDL_RESET_WORD;
         ar_delta_reg  <= `TDL_RESET_WORD;
         gb_start_reg  <= `TDL_RESET_WORD;
         ar_start_reg  <= `TDL_RESET_WORD;
         z_delta_reg   <= `TDL_RESET_WORD;
         z_start_reg   <= `TDL_RESET_WORD;
         endpoints_reg <= `TDL_RESET_WORD;
         x_delta_reg   <= `TDL_RESET_WORD;
         x_start_reg   <= `TDL_RESET_WORD;
         y_start_reg   <= 11'h000;
         y_count_reg   <= `TDL_RESET_WORD;
      end
      else if (wr_en)
      begin
         case (paddr)
            `TDL_OFF_GB_DELTA:  gb_delta_reg  <= pwdata;
            `TDL_OFF_AR_DELTA:  ar_delta_reg  <= pwdata;
            `TDL_OFF_GB_START:  gb_start_reg  <= pwdata;
            `TDL_OFF_AR_START:  ar_start_reg  <= pwdata;
            `TDL_OFF_Z_DELTA:   z_delta_reg   <= pwdata;
            `TDL_OFF_Z_START:   z_start_reg   <= pwdata;
            `TDL_OFF_ENDPOINTS: endpoints_reg <= pwdata;
            `TDL_OFF_X_DELTA:   x_delta_reg   <= pwdata;
            `TDL_OFF_X_START:   x_start_reg   <= pwdata;
            `TDL_OFF_Y_START:   y_start_reg   <= pwdata[10:0];
            `TDL_OFF_Y_COUNT:   y_count_reg   <= pwdata;
            default:            y_start_reg   <= y_start_reg;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Command word and auto-execute mode
   // Auto mode survives any number of lines; only a no-op or a command
   // write with the auto bit clear takes the engine out of it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_reg               <= `TDL_RESET_WORD;
         auto_execute_flag_reg <= 1'b0;
      end
      else if (wr_en && paddr == `TDL_OFF_CMD)
      begin
         cmd_reg <= pwdata;
         if (opcode == `TDL_OP_NOP)
            auto_execute_flag_reg <= 1'b0;
         else
            auto_execute_flag_reg <= pwdata[`TDL_BIT_AUTO];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Line stepping engine; reserved opcodes never start a line
   // One clock per scanline; a count write during a line updates the
   // register but never restarts the engine.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg      <= tdl_pkg::TDL_IDLE;
         remain_reg     <= 11'h000;
         span_y         <= 11'h000;
         span_x         <= 32'h0000_0000;
         span_depth     <= 32'h0000_0000;
         colour_acc_reg <= 64'h0;
         span_valid     <= 1'b0;
         line_busy      <= 1'b0;
         span_left_to_right <= 1'b0;
      end
      else
      begin
         case (state_reg)
            tdl_pkg::TDL_IDLE:
            begin
               if (start_line)
               begin
                  // First scanline shows the start values unchanged, so
                  // the loaded Y start really is the first line drawn.
                  // A zero count loads and retires without a scanline.
                  remain_reg <= line_count;
                  span_valid <= (line_count != 11'h000);
                  span_left_to_right <= (paddr == `TDL_OFF_Y_COUNT) ?
                     pwdata[`TDL_DIR_BIT] : y_count_reg[`TDL_DIR_BIT];
                  span_y         <= y_start_reg;
                  span_x         <= x_start_reg;
                  span_depth     <= z_start_reg;
                  colour_acc_reg <= {ar_start_reg, gb_start_reg};
                  line_busy      <= 1'b1;
                  state_reg      <= tdl_pkg::TDL_STEP;
               end
               else
               begin
                  span_valid <= 1'b0;
               end
            end
            tdl_pkg::TDL_STEP:
            begin
               // Remain includes the scanline on show; retire after it
               if (remain_reg <= 11'h001)
               begin
                  span_valid <= 1'b0;
                  line_busy  <= 1'b0;
                  state_reg  <= tdl_pkg::TDL_IDLE;
               end
               else
               begin
                  span_valid <= 1'b1;
                  remain_reg <= remain_reg - 11'h001;
                  span_y     <= span_y - 11'h001;
                  span_x     <= span_x + x_delta_reg;
                  span_depth <= span_depth + z_delta_reg;
                  colour_acc_reg[15:0]  <= colour_acc_reg[15:0] +
                     gb_delta_reg[15:0];
                  colour_acc_reg[31:16] <= colour_acc_reg[31:16] +
                     gb_delta_reg[31:16];
                  colour_acc_reg[47:32] <= colour_acc_reg[47:32] +
                     ar_delta_reg[15:0];
                  colour_acc_reg[63:48] <= colour_acc_reg[63:48] +
                     ar_delta_reg[31:16];
               end
            end
            default: state_reg <= tdl_pkg::TDL_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Decoded controls registered for the pixel pipeline
   // The copies lag the command word by one cycle; the pipeline must not
   // use them in the cycle right after a command write.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         texture_blend_select <= 2'h0;
         fog_blend_on         <= 1'b0;
         alpha_blend_on       <= 1'b0;
         alpha_blend_source   <= 1'b0;
         depth_test_select    <= 3'h0;
         depth_buffer_scheme  <= 2'h0;
         texture_wrap_on      <= 1'b0;
         command_class_flag   <= 1'b0;
         span_depth_write_on  <= 1'b0;
         span_colour          <= 64'h0;
      end
      else
      begin
         texture_blend_select <= cmd_reg[`TDL_TB_LSB +: 2];
         fog_blend_on <= cmd_reg[`TDL_FOG_BIT];
         alpha_blend_on     <= cmd_reg[`TDL_ABC_LSB + 1];
         alpha_blend_source <= cmd_reg[`TDL_ABC_LSB];
         depth_test_select <= cmd_reg[`TDL_ZCMP_LSB +: 3];
         span_depth_write_on <= cmd_reg[`TDL_ZUP_BIT] &&
            cmd_reg[`TDL_ZCMP_LSB +: 3] != 3'h0;
         depth_buffer_scheme <= cmd_reg[`TDL_ZMODE_LSB +: 2];
         texture_wrap_on <= cmd_reg[`TDL_WRAP_BIT];
         command_class_flag <= line_busy;
         span_colour <= colour_acc_reg;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read mux; status word shows engine state and remaining count
   // Bit 31 of the command read-back is the busy state, not the stored
   // class bit, so software can poll one word for completion.
   always_comb
   begin
      hit     = 1'b1;
      rd_next = 32'h0000_0000;
      case (paddr)
         `TDL_OFF_CMD:
            rd_next = {line_busy, cmd_reg[30:1], auto_execute_flag_reg};
         `TDL_OFF_GB_DELTA:  rd_next = gb_delta_reg;
         `TDL_OFF_AR_DELTA:  rd_next = ar_delta_reg;
         `TDL_OFF_GB_START:  rd_next = gb_start_reg;
         `TDL_OFF_AR_START:  rd_next = ar_start_reg;
         `TDL_OFF_Z_DELTA:   rd_next = z_delta_reg;
         `TDL_OFF_Z_START:   rd_next = z_start_reg;
         `TDL_OFF_ENDPOINTS: rd_next = endpoints_reg;
         `TDL_OFF_X_DELTA:   rd_next = x_delta_reg;
         `TDL_OFF_X_START:   rd_next = x_start_reg;
         `TDL_OFF_Y_START:   rd_next = {21'h0, y_start_reg};
         `TDL_OFF_Y_COUNT:
            rd_next = {y_count_reg[31], 20'h0, y_count_reg[10:0]};
         `TDL_OFF_STATUS:    rd_next = {20'h0, line_busy, remain_reg};
         default:            hit = 1'b0;
      endcase
   end

   // Zero-wait answer; ready, error and read data are registered from the setup phase
   // Ready comes from the setup phase, so a master that stretches the
   // access phase sees ready drop again; wait states are not supported.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_next : 32'h0000_0000;
      end
   end

endmodule : tdl_line_setup
`default_nettype wire

// ===== src/tdl_pkg.sv
// Types for the 3D line setup bank.
// Assumes nothing beyond the constants header.
package tdl_pkg;

   // Engine sequencing states
   typedef enum logic [1:0] {
      TDL_IDLE = 2'b00,
      TDL_STEP = 2'b01
   } tdl_state_e;

endpackage : tdl_pkg

// ===== tb/tb_three_d_line_setup_regs.sv
// Self-checking bench for the 3D line setup bank over APB.
// Assumes the bound checker; the run needs only a few hundred cycles.
`timescale 1ns/100ps
`default_nettype none
`include "tdl_consts.svh"
module tb_three_d_line_setup_regs;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, er, line_busy, span_valid;
   logic        span_left_to_right, span_depth_write_on, fog_blend_on;
   logic        alpha_blend_on, alpha_blend_source, texture_wrap_on;
   logic        command_class_flag;
   logic [1:0]  texture_blend_select, depth_buffer_scheme;
   logic [2:0]  depth_test_select;
   logic [10:0] span_y;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, span_x, span_depth, rd;
   logic [63:0] span_colour;
   int          num_errors = 0, n_checks = 0, pulse_cnt = 0;
   logic [15:0] offs [10] = '{`TDL_OFF_GB_DELTA, `TDL_OFF_AR_DELTA,
      `TDL_OFF_GB_START, `TDL_OFF_AR_START, `TDL_OFF_Z_DELTA,
      `TDL_OFF_Z_START, `TDL_OFF_ENDPOINTS, `TDL_OFF_X_DELTA,
      `TDL_OFF_X_START, `TDL_OFF_Y_START};
   logic [31:0] vals [10] = '{32'h0100_ff80, 32'hffc0_0040, 32'h1000_2000,
      32'h3000_4000, 32'hffff_8000, 32'h0010_0000, 32'h0005_0002,
      32'h0008_0000, 32'h0100_0000, 32'h0000_0064};

   tdl_line_setup u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .line_busy, .span_left_to_right,
      .span_y, .span_x, .span_depth, .span_colour, .span_valid,
      .span_depth_write_on, .texture_blend_select, .fog_blend_on,
      .alpha_blend_on, .alpha_blend_source, .depth_test_select,
      .depth_buffer_scheme, .texture_wrap_on, .command_class_flag);

   // 25 MHz clock
   initial
      forever #20 pclk = ~pclk;
   // Hang guard, far beyond what the tests need
   initial
   begin
      #200000;
      num_errors++;
      finish_test();
   end
   // Scanline pulses, counted apart from any task
   always @(posedge pclk)
      if (span_valid === 1'b1)
         pulse_cnt <= pulse_cnt + 1;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         num_errors++;
      end
   endtask : chk
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait-state count assumed; the hang guard ends a stuck access
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic finish_test;
      if (num_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   // All legal codes of each field through the copies; reserved 11 avoided
   task automatic t_fields;
      logic [31:0] w;
      logic [1:0]  c;
      for (int i = 0; i < 8; i++)
      begin
         c = (i[1:0] == 2'b11) ? 2'b10 : i[1:0];
         w = {5'h01, i[0], c, i[1], i[2:0], i[1:0], i[2] & ~&i[1:0], c,
              15'h0001};
         apb(1'b1, `TDL_OFF_CMD, w);
         repeat (2) @(posedge pclk);
         chk(texture_blend_select, w[16:15]);
         chk(fog_blend_on, w[17]);
         chk({alpha_blend_on, alpha_blend_source}, w[19:18]);
         chk(depth_test_select, w[22:20]);
         chk(span_depth_write_on, w[23] && w[22:20] != 0);
         chk(depth_buffer_scheme, w[25:24]);
         chk(texture_wrap_on, w[26]);
      end
   endtask : t_fields
   // Follow one line; step differences must equal the loaded deltas
   task automatic run_line(input int n, input logic dir);
      logic [31:0] px, pz;
      logic [10:0] py;
      logic [63:0] pc;
      int          k;
      logic        cv;
      k = 0;
      cv = 1'b0;
      // First scanline stands from the launch edge: look, then wait
      for (int t = 0; t < 64 && (t < 2 || line_busy === 1'b1 || cv); t++)
      begin
         #1;
         if (cv && k == 1)
            chk(span_colour, {vals[3], vals[2]});
         if (cv && k > 1)
            chk(span_colour, {pc[63:48] + vals[1][31:16],
               pc[47:32] + vals[1][15:0], pc[31:16] + vals[0][31:16],
               pc[15:0] + vals[0][15:0]});
         if (cv)
            pc = span_colour;
         cv = 1'b0;
         if (span_valid === 1'b1)
         begin
            if (k == 0)
            begin
               chk(span_y, vals[9][10:0]);
               chk(span_x, vals[8]);
               chk(span_depth, vals[5]);
            end
            else
            begin
               chk(command_class_flag, 1'b1);
               chk(span_x, 32'(px + vals[7]));
               chk(span_depth, 32'(pz + vals[4]));
               chk(span_y, 11'(py - 11'd1));
            end
            px = span_x;
            pz = span_depth;
            py = span_y;
            k++;
            cv = 1'b1;
         end
         @(posedge pclk);
      end
      chk(64'(k), 64'(n));
      chk(span_left_to_right, dir);
   endtask : run_line
   // Load, read back, auto lines, no-op cancel, direct line start with a count write while busy
   task automatic t_line;
      int p;
      for (int i = 0; i < 10; i++)
      begin
         apb(1'b1, offs[i], vals[i]);
         apb(1'b0, offs[i], 32'h0);
         chk(rd, vals[i]);
      end
      apb(1'b1, `TDL_OFF_CMD, 32'h4000_0001);
      repeat (3) @(posedge pclk);
      chk(line_busy, 0);
      apb(1'b1, `TDL_OFF_Y_COUNT, 32'h8000_0003);
      run_line(3, 1'b1);
      apb(1'b1, `TDL_OFF_Y_COUNT, 32'h0000_0002);
      run_line(2, 1'b0);
      apb(1'b1, `TDL_OFF_CMD, 32'h7800_0001);
      apb(1'b0, `TDL_OFF_CMD, 32'h0);
      chk(rd[0], 0);
      apb(1'b1, `TDL_OFF_Y_COUNT, 32'h8000_0005);
      repeat (3) @(posedge pclk);
      chk(line_busy, 0);
      p = pulse_cnt;
      apb(1'b1, `TDL_OFF_CMD, 32'h4000_0000);
      apb(1'b1, `TDL_OFF_Y_COUNT, 32'h8000_0003);
      for (int n = 0; n < 50 && line_busy !== 1'b0; n++)
         @(posedge pclk);
      repeat (2) @(posedge pclk);
      chk(64'(pulse_cnt - p), 64'd5);
      chk(span_left_to_right, 1);
   endtask : t_line
   // Main sequence
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 16'hb104, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      t_fields();
      t_line();
      finish_test();
   end
endmodule : tb_three_d_line_setup_regs
`default_nettype wire

// ===== tb/tdl_line_setup_props.sv
// Property checker for the 3D line setup bank, bound to its top module.
// Assumes one-cycle APB access and at most two cycles of field lag.
`timescale 1ns/100ps
`default_nettype none
`include "tdl_consts.svh"
module tdl_line_setup_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        line_busy,
   input wire logic        span_depth_write_on,
   input wire logic [1:0]  texture_blend_select,
   input wire logic        fog_blend_on,
   input wire logic        alpha_blend_on,
   input wire logic        alpha_blend_source,
   input wire logic [2:0]  depth_test_select,
   input wire logic        command_class_flag
);
   logic [31:0] cq;
   wire logic   cmd_wr = psel && penable && pwrite && paddr == `TDL_OFF_CMD;
   wire logic   idle_wr = cmd_wr && !line_busy;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Last committed command word; APB spacing keeps it valid two cycles on
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         cq <= 32'h0000_0000;
      else if (cmd_wr)
         cq <= pwdata;
   ////////////////////////////////////////////////////////////////////////////
   // Command writes by kind
   sequence s_cmd; idle_wr && pwdata[30:27] != 4'hf; endsequence
   sequence s_nop; idle_wr && pwdata[30:27] == 4'hf; endsequence
   sequence s_go; idle_wr && pwdata[30:27] == 4'h8 && !pwdata[0]; endsequence
   property p_blend; s_cmd |-> ##2 texture_blend_select == cq[16:15];
   endproperty
   property p_fog; s_cmd |-> ##2 fog_blend_on == cq[17]; endproperty
   property p_alpha; s_cmd |-> ##2
      {alpha_blend_on, alpha_blend_source} == cq[19:18]; endproperty
   property p_ztest; s_cmd |-> ##2 depth_test_select == cq[22:20]; endproperty
   property p_zwr; s_cmd |-> ##2
      span_depth_write_on == (cq[23] && cq[22:20] != 3'h0); endproperty
   property p_class; $stable(line_busy) |->
      command_class_flag == line_busy; endproperty
   property p_nop; s_nop |=> !line_busy [*2]; endproperty
   property p_go; s_go |=> line_busy; endproperty
   a_blend: assert property (p_blend) else $error("blend copy wrong");
   a_fog: assert property (p_fog) else $error("fog copy wrong");
   a_alpha: assert property (p_alpha) else $error("alpha copy wrong");
   a_ztest: assert property (p_ztest) else $error("z test wrong");
   a_zwr: assert property (p_zwr) else $error("z write wrong");
   a_class: assert property (p_class) else $error("class flag wrong");
   a_nop: assert property (p_nop) else $error("no-op drew");
   a_go: assert property (p_go) else $error("line not started");
endmodule : tdl_line_setup_props

bind tdl_line_setup tdl_line_setup_props u_props (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .line_busy, .span_depth_write_on,
   .texture_blend_select, .fog_blend_on, .alpha_blend_on,
   .alpha_blend_source, .depth_test_select, .command_class_flag);
`default_nettype wire
